// ---- tro_map.svh ----
`ifndef TRO_MAP_SVH
`define TRO_MAP_SVH
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define TRO_CMD_PAGE 8'h00
`define TRO_CMD_IIN 8'h89
`define TRO_CMD_TEMP 8'h8d
`define TRO_CMD_POUT 8'h96
`define TRO_CMD_PIN 8'h97
`define TRO_CMD_VLIN 8'hd4
`define TRO_CMD_CFGA 8'hda
`define TRO_CMD_CFGB 8'hdc
// ----------------------------------------------------------------
// page selector values
// ----------------------------------------------------------------
`define TRO_PAGE_A 8'h00
`define TRO_PAGE_B 8'h01
`define TRO_PAGE_ALL 8'hff
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TRO_EXP_HI 15
`define TRO_EXP_LO 11
`define TRO_MAN_HI 10
`define TRO_TRIM_HI 15
`define TRO_TRIM_LO 8
`define TRO_RANGE_BIT 13
`define TRO_OFS_HI 12
`define TRO_OFS_LO 8
`define TRO_RCODE_HI 15
`define TRO_RCODE_LO 14
`define TRO_CML_BADCMD 7
`define TRO_CML_BADDATA 6
// ----------------------------------------------------------------
// reset values and fixed exponents
// ----------------------------------------------------------------
`define TRO_CFGA_P0_RST 16'h3200
`define TRO_CFGA_P1_RST 16'h0000
`define TRO_CFGB_P0_RST 16'h0000
`define TRO_CFGB_MASK 16'hdfff
`define TRO_TRIM_NOM 8'h32
`define TRO_EXP_TEMP 5'h00
`define TRO_EXP_POUT 5'h1e
`define TRO_EXP_PIN 5'h1f
`define TRO_EXP_VOUT 5'h18
`define TRO_EXP_IIN 5'h1c
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TRO_REFRESH_US 1200
`define TRO_CLK_MHZ 125
`define TRO_REFRESH_CYCLES (`TRO_REFRESH_US * `TRO_CLK_MHZ)
`endif

// ---- tro_pkg.sv ----
package tro_pkg;
  // one host command as seen at the command port
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } tro_req_s;
  // calibration settings handed to the current calibrator
  typedef struct packed {
    logic rangeSel;
    logic [1:0] rcode;
    logic [7:0] trim;
    logic [4:0] ofs;
  } tro_cal_s;
endpackage

// ---- tro_iin_cal.sv ----
`timescale 1ns/1ps
`include "tro_map.svh"
module tro_iin_cal
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] senseUv,
  input wire tro_pkg::tro_cal_s cal,
  output logic signed [10:0] iinQ
);
  // ----------------------------------------------------------------
  // analog gain in units of 0.05 milliohm, index {range, rcode}
  // ----------------------------------------------------------------
  localparam logic [6:0] GAIN [8] = '{7'h03, 7'h05, 7'h06, 7'h0a,
                                      7'h18, 7'h28, 7'h30, 7'h50};
  localparam logic [31:0] LIM_LOW = 32'h0000_0320; // 50.0 a in 1/16 a
  localparam logic [31:0] LIM_HIGH = 32'h0000_0064; // 6.25 a in 1/16 a
  logic [6:0] gain;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quo;
  logic [31:0] lim;
  logic signed [11:0] ofsQ;
  logic signed [11:0] sum;
  // current in 1/16 a: uv*16*trim / (gain*50*50)
  always_comb
  begin
    gain = GAIN[{cal.rangeSel, cal.rcode}];
    num = 32'(senseUv) * 32'h10 * 32'(cal.trim);
    den = 32'(gain) * 32'h9c4;
    quo = num / den;
    lim = cal.rangeSel ? LIM_HIGH : LIM_LOW;
    if (quo > lim)
    begin
      quo = lim;
    end
    // offset code is tenths of an ampere, two's complement
    ofsQ = 12'((13'(signed'(cal.ofs)) * 13'sd16) / 13'sd10);
    sum = signed'(12'(quo)) + ofsQ;
  end
  // registered result
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      iinQ <= '0;
    end
    else
    begin
      iinQ <= 11'(sum);
    end
  end
  property p_iin_limit;
    @(posedge clk) disable iff (rst)
    cal.rangeSel && $stable(cal) && $stable(senseUv) |=>
      iinQ <= 11'sd100 + 11'sd24;
  endproperty
  a_iin_limit: assert property (p_iin_limit)
    else $error("input current above range limit");
endmodule // tro_iin_cal

// ---- tro_telemetry.sv ----
// Overview of operation
// - Writes to read-only readbacks flag and alert
// - Output power per channel, refreshed each 1200us
// - Page 00h a, 01h b, ffh both on writes, a on reads
// - One shared input power, refreshed each 1200us
// - Input power ignores the page selector
// - Exponent bits 15:11, mantissa bits 10:0
// - Command d4h returns paged linear output voltage
// - Input current reading is both channels total
// - Gain from range bit and resistance code
// - Gain range limits measurable input current
// - Current scaled by trim over nominal 50
// - Programmed offset added to sensed current
// - Offset codes: 0..1.5a, then -1.6..-0.1a
// - Trim in bits 15:8 of config a page 0
// - Range bit 13 of config a page 1
// - Resistance code bits 15:14 config b page 0
`timescale 1ns/1ps
`include "tro_map.svh"
module tro_telemetry
#(
  parameter int REFRESH_CYCLES = `TRO_REFRESH_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire tro_pkg::tro_req_s req,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspInvalid,
  input wire logic clearFaults,
  input wire logic [1:0][10:0] tempIn,
  input wire logic [1:0][10:0] voutIn,
  input wire logic [1:0][10:0] ioutIn,
  input wire logic [10:0] vinIn,
  input wire logic [15:0] senseUv,
  output logic [7:0] commStatus,
  output logic statusWordCml,
  output logic hostAlertLine_n
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int CW = $clog2(REFRESH_CYCLES);
  if (REFRESH_CYCLES < 2)
  begin : g_bad_refresh
    $error("refresh period too short");
  end
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [CW-1:0] refreshCnt_q; // cycles since last refresh
  logic tick; // one-cycle refresh strobe
  logic [7:0] page_q; // page selector
  logic [15:0] cfgAP0_q; // config a, page 0 word
  logic [15:0] cfgAP1_q; // config a, page 1 word
  logic [15:0] cfgBP0_q; // config b, page 0 word
  logic [7:0] commStatus_q; // sticky communication flags
  logic [1:0][15:0] tempSnap_q;
  logic [1:0][15:0] poutSnap_q;
  logic [1:0][15:0] vlinSnap_q;
  logic [15:0] pinSnap_q;
  logic [15:0] iinSnap_q;
  logic signed [10:0] iinQ; // calibrated input current, 1/16 a
  tro_pkg::tro_cal_s cal;
  logic isRead;
  logic isWrite;
  logic roCmd; // read-only telemetry command
  logic rwCmd; // writable command
  logic badPage; // page write with an unsupported value
  logic chanB; // paged access routed to channel b
  logic [15:0] readWord;
  logic [21:0] pinProd;
  logic [15:0] pinWord;
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    isRead = reqValid && !req.write;
    isWrite = reqValid && req.write;
    roCmd = (req.code == `TRO_CMD_IIN) || (req.code == `TRO_CMD_TEMP) ||
            (req.code == `TRO_CMD_POUT) || (req.code == `TRO_CMD_PIN) ||
            (req.code == `TRO_CMD_VLIN);
    rwCmd = (req.code == `TRO_CMD_PAGE) || (req.code == `TRO_CMD_CFGA) ||
            (req.code == `TRO_CMD_CFGB);
    badPage = isWrite && (req.code == `TRO_CMD_PAGE) &&
              (req.data[7:0] != `TRO_PAGE_A) &&
              (req.data[7:0] != `TRO_PAGE_B) &&
              (req.data[7:0] != `TRO_PAGE_ALL);
    chanB = (page_q == `TRO_PAGE_B);
  end
  // read data multiplexer; page ff reads channel a
  always_comb
  begin
    case (req.code)
      `TRO_CMD_PAGE: readWord = {8'h00, page_q};
      `TRO_CMD_TEMP: readWord = tempSnap_q[chanB];
      `TRO_CMD_POUT: readWord = poutSnap_q[chanB];
      `TRO_CMD_PIN: readWord = pinSnap_q;
      `TRO_CMD_IIN: readWord = iinSnap_q;
      `TRO_CMD_VLIN: readWord = vlinSnap_q[chanB];
      `TRO_CMD_CFGA: readWord = chanB ? cfgAP1_q : cfgAP0_q;
      `TRO_CMD_CFGB: readWord = cfgBP0_q & `TRO_CFGB_MASK;
      default: readWord = 16'h0000;
    endcase
  end
  // ----------------------------------------------------------------
  // refresh timer
  // ----------------------------------------------------------------
  assign tick = (refreshCnt_q == CW'(REFRESH_CYCLES - 1));
  // counts one refresh period, strobing tick at its end
  always_ff @(posedge clk)
  begin
    if (rst || tick)
    begin
      refreshCnt_q <= '0;
    end
    else
    begin
      refreshCnt_q <= refreshCnt_q + CW'(1);
    end
  end
  // ----------------------------------------------------------------
  // input current calibration
  // ----------------------------------------------------------------
  assign cal.trim = cfgAP0_q[`TRO_TRIM_HI:`TRO_TRIM_LO];
  assign cal.rangeSel = cfgAP1_q[`TRO_RANGE_BIT];
  assign cal.ofs = cfgAP1_q[`TRO_OFS_HI:`TRO_OFS_LO];
  assign cal.rcode = cfgBP0_q[`TRO_RCODE_HI:`TRO_RCODE_LO];
  tro_iin_cal u_cal
  (
    .clk(clk),
    .rst(rst),
    .senseUv(senseUv),
    .cal(cal),
    .iinQ(iinQ)
  );
  // ----------------------------------------------------------------
  // shared input power, vin 2^-5 v times iin 2^-4 a, 2^-1 w
  // ----------------------------------------------------------------
  always_comb
  begin
    pinProd = iinQ[10] ? 22'h0 : 22'(vinIn) * 22'(iinQ);
    if (pinProd[21:8] > 14'h3ff)
    begin
      pinWord = {`TRO_EXP_PIN, 11'h3ff};
    end
    else
    begin
      pinWord = {`TRO_EXP_PIN, 1'b0, pinProd[17:8]};
    end
  end
  // shared snapshots, whole words updated only on tick
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinSnap_q <= '0;
      iinSnap_q <= '0;
    end
    else if (tick)
    begin
      pinSnap_q <= pinWord;
      iinSnap_q <= {`TRO_EXP_IIN, iinQ};
    end
  end
  // ----------------------------------------------------------------
  // per-channel snapshots: temperature, power, linear voltage
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    logic [21:0] prod; // vout 2^-8 v times iout 2^-2 a
    logic [10:0] pman; // power mantissa, 2^-2 w
    assign prod = 22'(voutIn[ch]) * 22'(ioutIn[ch]);
    assign pman = (prod[21:8] > 14'h3ff) ? 11'h3ff : {1'b0, prod[17:8]};
    // hold each word until the next refresh
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        tempSnap_q[ch] <= '0;
        poutSnap_q[ch] <= '0;
        vlinSnap_q[ch] <= '0;
      end
      else if (tick)
      begin
        tempSnap_q[ch] <= {`TRO_EXP_TEMP, tempIn[ch]};
        poutSnap_q[ch] <= {`TRO_EXP_POUT, pman};
        vlinSnap_q[ch] <= {`TRO_EXP_VOUT, voutIn[ch]};
      end
    end
  end
  // ----------------------------------------------------------------
  // page and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      page_q <= `TRO_PAGE_A;
    end
    else if (isWrite && req.code == `TRO_CMD_PAGE && !badPage)
    begin
      page_q <= req.data[7:0];
    end
  end
  // page ff writes both pages of config a
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfgAP0_q <= `TRO_CFGA_P0_RST;
      cfgAP1_q <= `TRO_CFGA_P1_RST;
      cfgBP0_q <= `TRO_CFGB_P0_RST;
    end
    else if (isWrite)
    begin
      if (req.code == `TRO_CMD_CFGA && page_q != `TRO_PAGE_B)
      begin
        cfgAP0_q <= req.data;
      end
      if (req.code == `TRO_CMD_CFGA && page_q != `TRO_PAGE_A)
      begin
        cfgAP1_q <= req.data;
      end
      if (req.code == `TRO_CMD_CFGB && page_q != `TRO_PAGE_B)
      begin
        cfgBP0_q <= req.data & `TRO_CFGB_MASK;
      end
    end
  end
  // ----------------------------------------------------------------
  // communication status, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      commStatus_q <= '0;
    end
    else
    begin
      commStatus_q[`TRO_CML_BADCMD] <=
        (commStatus_q[`TRO_CML_BADCMD] && !clearFaults) ||
        (isWrite && roCmd) || (reqValid && !roCmd && !rwCmd);
      commStatus_q[`TRO_CML_BADDATA] <=
        (commStatus_q[`TRO_CML_BADDATA] && !clearFaults) || badPage;
    end
  end
  assign commStatus = commStatus_q;
  assign statusWordCml = |commStatus_q;
  assign hostAlertLine_n = !(|commStatus_q);
  // ----------------------------------------------------------------
  // response, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rspValid <= 1'b0;
      rspData <= '0;
      rspInvalid <= 1'b0;
    end
    else
    begin
      rspValid <= reqValid;
      rspData <= isRead ? readWord : 16'h0000;
      rspInvalid <= reqValid && ((req.write && roCmd) || badPage ||
                                 (!roCmd && !rwCmd));
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ro_write;
    @(posedge clk) disable iff (rst)
    isWrite && roCmd |=> rspInvalid && !hostAlertLine_n && statusWordCml;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write not flagged");
  property p_period;
    @(posedge clk) disable iff (rst)
    tick |=> !tick && refreshCnt_q == '0;
  endproperty
  a_period: assert property (p_period)
    else $error("refresh period broken");
  property p_hold;
    @(posedge clk) disable iff (rst)
    !tick |=> $stable(poutSnap_q) && $stable(pinSnap_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("snapshot changed between refreshes");
  property p_pin_shared;
    @(posedge clk) disable iff (rst)
    isRead && req.code == `TRO_CMD_PIN |=> rspData == $past(pinSnap_q);
  endproperty
  a_pin_shared: assert property (p_pin_shared)
    else $error("input power read depends on page");
  property p_exp;
    @(posedge clk) disable iff (rst)
    tick |=> poutSnap_q[0][`TRO_EXP_HI:`TRO_EXP_LO] == `TRO_EXP_POUT &&
             pinSnap_q[`TRO_EXP_HI:`TRO_EXP_LO] == `TRO_EXP_PIN;
  endproperty
  a_exp: assert property (p_exp)
    else $error("linear exponent field wrong");
  property p_page;
    @(posedge clk) disable iff (rst)
    isWrite && req.code == `TRO_CMD_PAGE && req.data[7:0] == `TRO_PAGE_ALL
      |=> page_q == `TRO_PAGE_ALL;
  endproperty
  a_page: assert property (p_page)
    else $error("page ff not accepted");
  property p_vlin_b;
    @(posedge clk) disable iff (rst)
    isRead && req.code == `TRO_CMD_VLIN && page_q == `TRO_PAGE_B
      |=> rspData == $past(vlinSnap_q[1]);
  endproperty
  a_vlin_b: assert property (p_vlin_b)
    else $error("linear voltage not routed to channel b");
  property p_trim;
    @(posedge clk) disable iff (rst)
    isWrite && req.code == `TRO_CMD_CFGA && page_q == `TRO_PAGE_A
      |=> cal.trim == $past(req.data[15:8]) && $stable(cfgAP1_q);
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim not taken from page 0 word");
endmodule // tro_telemetry

// ---- tro_host.sv ----
`timescale 1ns/1ps
`include "tro_map.svh"
// ----------------------------------------------------------------
// host controller model on the command port
// ----------------------------------------------------------------
module tro_host
(
  input wire logic clk,
  output logic reqValid,
  output tro_pkg::tro_req_s req,
  input wire logic rspValid,
  input wire logic [15:0] rspData,
  input wire logic rspInvalid
);
  // idle request lines at time zero
  initial
  begin
    reqValid = 1'b0;
    req = '0;
  end

  // one whole word per command, read answer taken one edge later
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [15:0] data, output logic [15:0] rd,
    output logic [1:0] st);
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{write: wr, code: code, data: data};
    @(posedge clk);
    reqValid <= 1'b0;
    // released lines change so a stale word is never seen
    req <= ~req;
    @(negedge clk);
    rd = rspData;
    st = {rspValid, rspInvalid};
  endtask

  // page selector written with whatever 8-bit value is given
  task automatic setPage(input logic [7:0] pg, output logic [1:0] st);
    logic [15:0] d;
    xfer(1'b1, `TRO_CMD_PAGE, {8'h00, pg}, d, st);
  endtask
endmodule // tro_host

// ---- tro_telemetry_tb.sv ----
`timescale 1ns/1ps
`include "tro_map.svh"
// ----------------------------------------------------------------
// bench for the telemetry readout
// ----------------------------------------------------------------
module tro_telemetry_tb;
  localparam int REF = 32;
  localparam int SETTLE = 2 * REF + 4;
  logic clk, rst, reqValid, rspValid, rspInvalid, clearFaults;
  tro_pkg::tro_req_s req;
  logic [15:0] rspData, senseUv;
  logic [1:0][10:0] tempIn, voutIn, ioutIn;
  logic [10:0] vinIn;
  logic [7:0] commStatus;
  logic statusWordCml, hostAlertLine_n;
  int num_errors = 0;
  int compares = 0;

  tro_telemetry #(.REFRESH_CYCLES(REF)) uut (.clk(clk), .rst(rst),
    .reqValid(reqValid), .req(req), .rspValid(rspValid),
    .rspData(rspData), .rspInvalid(rspInvalid),
    .clearFaults(clearFaults), .tempIn(tempIn), .voutIn(voutIn),
    .ioutIn(ioutIn), .vinIn(vinIn), .senseUv(senseUv),
    .commStatus(commStatus), .statusWordCml(statusWordCml),
    .hostAlertLine_n(hostAlertLine_n));

  tro_host host (.clk(clk), .reqValid(reqValid), .req(req),
    .rspValid(rspValid), .rspData(rspData), .rspInvalid(rspInvalid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // read one word, expect a valid answer
  task automatic rd(input logic [7:0] code, output logic [15:0] d);
    logic [1:0] st;
    host.xfer(1'b0, code, 16'h0000, d, st);
    check({14'h0, st}, 16'h0002);
  endtask

  // write one word, expect the given refusal state
  task automatic wr(input logic [7:0] code, input logic [15:0] data,
    input logic inv);
    logic [15:0] d;
    logic [1:0] st;
    host.xfer(1'b1, code, data, d, st);
    check({14'h0, st}, {14'h0, 1'b1, inv});
    check(d, 16'h0000);
  endtask

  // sticky flags, summary and alert agree
  task automatic flags(input logic [7:0] f);
    check({8'h00, commStatus}, {8'h00, f});
    check({15'h0, statusWordCml}, {15'h0, |f});
    check({15'h0, hostAlertLine_n}, {15'h0, ~|f});
  endtask

  // one clear pulse
  task automatic clr;
    @(posedge clk) clearFaults <= 1'b1;
    @(posedge clk) clearFaults <= 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // state after reset and config defaults
  task automatic t_reset;
    logic [15:0] d;
    flags(8'h00);
    rd(`TRO_CMD_CFGA, d);
    check(d, 16'h3200);
    wr(`TRO_CMD_PAGE, 16'h0001, 1'b0);
    rd(`TRO_CMD_CFGA, d);
    check(d, 16'h0000);
    wr(`TRO_CMD_PAGE, 16'h0000, 1'b0);
    rd(`TRO_CMD_CFGB, d);
    check(d, 16'h0000);
  endtask

  // paged readbacks on every page value, shared ones alike
  task automatic t_paged;
    logic [15:0] d;
    logic [7:0] pg [3] = '{8'h00, 8'h01, 8'hff};
    int c;
    @(posedge clk);
    tempIn <= {11'h7f6, 11'h019};
    voutIn <= {11'h080, 11'h100};
    ioutIn <= {11'h020, 11'h028};
    vinIn <= 11'd384;
    senseUv <= 16'd1500;
    repeat (SETTLE) @(posedge clk);
    foreach (pg[i])
    begin
      wr(`TRO_CMD_PAGE, {8'h00, pg[i]}, 1'b0);
      c = (pg[i] == `TRO_PAGE_B) ? 1 : 0;
      rd(`TRO_CMD_TEMP, d);
      check(d, {`TRO_EXP_TEMP, tempIn[c]});
      rd(`TRO_CMD_VLIN, d);
      check(d, {`TRO_EXP_VOUT, voutIn[c]});
      rd(`TRO_CMD_POUT, d);
      check(d, {`TRO_EXP_POUT,
        11'((22'(voutIn[c]) * ioutIn[c]) >> 8)});
      rd(`TRO_CMD_PIN, d);
      check(d, {`TRO_EXP_PIN, 11'd240});
      rd(`TRO_CMD_IIN, d);
      check(d, {`TRO_EXP_IIN, 11'd160});
    end
    wr(`TRO_CMD_PAGE, 16'h0000, 1'b0);
  endtask

  // word holds between ticks, ticks one period apart
  task automatic t_refresh;
    logic [15:0] d;
    int n;
    logic ok;
    time t0;
    @(posedge clk) tempIn[0] <= 11'h033;
    n = 0;
    d = '0;
    while (d !== {`TRO_EXP_TEMP, 11'h033} && n < 40)
    begin
      rd(`TRO_CMD_TEMP, d);
      n++;
    end
    check(d, {`TRO_EXP_TEMP, 11'h033});
    // time of the first read that saw the new word
    t0 = $time;
    @(posedge clk) tempIn[0] <= 11'h044;
    rd(`TRO_CMD_TEMP, d);
    check(d, {`TRO_EXP_TEMP, 11'h033});
    n = 0;
    while (d !== {`TRO_EXP_TEMP, 11'h044} && n < 40)
    begin
      rd(`TRO_CMD_TEMP, d);
      n++;
    end
    // reads repeat every two cycles, so allow two cycles either way
    ok = ($time - t0 >= 8 * (REF - 2)) && ($time - t0 <= 8 * (REF + 2));
    check({15'h0, ok}, 16'h0001);
  endtask

  // calibration table: trim, range, offset, code, sense, current
  task automatic t_cal;
    logic [15:0] d;
    logic [42:0] e;
    logic [42:0] tb [15] = '{
      {8'd50, 1'b0, 5'h00, 2'd0, 16'd1500, 11'd160},
      {8'd25, 1'b0, 5'h00, 2'd0, 16'd1500, 11'd80},
      {8'd10, 1'b0, 5'h00, 2'd0, 16'd1500, 11'd32},
      {8'd64, 1'b0, 5'h00, 2'd3, 16'd1500, 11'd61},
      {8'd50, 1'b0, 5'h00, 2'd1, 16'd1500, 11'd96},
      {8'd50, 1'b0, 5'h00, 2'd2, 16'd1500, 11'd80},
      {8'd50, 1'b1, 5'h00, 2'd0, 16'd1500, 11'd20},
      {8'd50, 1'b1, 5'h00, 2'd1, 16'd1500, 11'd12},
      {8'd50, 1'b1, 5'h00, 2'd2, 16'd1500, 11'd10},
      {8'd50, 1'b1, 5'h00, 2'd3, 16'd1500, 11'd6},
      {8'd50, 1'b1, 5'h00, 2'd0, 16'd10000, 11'd100},
      {8'd50, 1'b0, 5'h00, 2'd0, 16'd9000, 11'd800},
      {8'd50, 1'b0, 5'h0f, 2'd0, 16'd1500, 11'd184},
      {8'd50, 1'b0, 5'h10, 2'd0, 16'd1500, 11'd135},
      {8'd50, 1'b0, 5'h1f, 2'd0, 16'd1500, 11'd159}};
    foreach (tb[i])
    begin
      e = tb[i];
      wr(`TRO_CMD_PAGE, 16'h0000, 1'b0);
      wr(`TRO_CMD_CFGA, {e[42:35], 8'h00}, 1'b0);
      wr(`TRO_CMD_PAGE, 16'h0001, 1'b0);
      wr(`TRO_CMD_CFGA, {2'b00, e[34:29], 8'h00}, 1'b0);
      wr(`TRO_CMD_PAGE, 16'h0000, 1'b0);
      wr(`TRO_CMD_CFGB, {e[28:27], 14'h0000}, 1'b0);
      rd(`TRO_CMD_CFGA, d);
      check(d, {e[42:35], 8'h00});
      @(posedge clk) senseUv <= e[26:11];
      repeat (SETTLE) @(posedge clk);
      rd(`TRO_CMD_IIN, d);
      check(d, {`TRO_EXP_IIN, e[10:0]});
    end
  endtask

  // writes to readbacks and a bad page are refused and flagged
  task automatic t_bad;
    logic [15:0] d;
    logic [1:0] st;
    logic [7:0] codes [6] = '{`TRO_CMD_IIN, `TRO_CMD_TEMP, `TRO_CMD_POUT,
      `TRO_CMD_PIN, `TRO_CMD_VLIN, 8'h55};
    foreach (codes[i])
    begin
      wr(codes[i], 16'hffff, 1'b1);
      flags(8'h80);
      rd(`TRO_CMD_TEMP, d);
      check(d, {`TRO_EXP_TEMP, tempIn[0]});
      clr;
      flags(8'h00);
    end
    wr(`TRO_CMD_PAGE, 16'h0002, 1'b1);
    flags(8'h40);
    // read-only write in the clear cycle: set wins, old flag goes
    fork
      wr(`TRO_CMD_POUT, 16'h1234, 1'b1);
      begin
        @(posedge clk) clearFaults <= 1'b1;
        @(posedge clk) clearFaults <= 1'b0;
      end
    join
    flags(8'h80);
    // read of an unknown code is refused with no data
    host.xfer(1'b0, 8'h55, 16'h0000, d, st);
    check({14'h0, st}, 16'h0003);
    check(d, 16'h0000);
    clr;
    flags(8'h00);
    wr(`TRO_CMD_PAGE, 16'h0000, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog against a hung sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict;
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    clearFaults = 1'b0;
    tempIn = '0;
    voutIn = '0;
    ioutIn = '0;
    vinIn = '0;
    senseUv = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // look at outputs away from the launching edge
    @(negedge clk);
    t_reset;
    t_paged;
    t_refresh;
    t_cal;
    t_bad;
    print_verdict;
  end
endmodule // tro_telemetry_tb
